// ==== src/adct_phase_timer.sv ====
// Down counter that times one converter phase
`timescale 1ns/1ps
module adct_phase_timer #(
    parameter int W = 10
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    // Load and expiry
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    output logic              expire
);
    import adct_pkg::*;

    if (W < 2) begin : g_check
        $error("adct_phase_timer: W too small");
    end

    typedef struct packed {
        logic [W-1:0] count;
        logic         running;
    } adct_timer_type;

    adct_timer_type s;
    adct_timer_type next_s;

    // Expires in the cycle its count reaches zero, so load_value+1 cycles pass
    assign expire = s.running && (s.count == '0);

    always_comb begin
        next_s = s;
        if (load) begin
            next_s.count   = load_value;
            next_s.running = 1'b1;
        end else if (s.running) begin
            if (s.count == '0) begin
                next_s.running = 1'b0;
            end else begin
                next_s.count = s.count - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    load_run_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        load |=> s.running && (s.count == $past(load_value)))
        else $error("timer did not start");

endmodule

// ==== src/adct_pkg.sv ====
// Package: register map, field layout and phase timing constants for the converter timing block
package adct_pkg;

    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int TIMER_W    = 10;

    // Register byte addresses
    localparam logic [AXI_ADDR_W-1:0] TIMING_ADDR  = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] TEST_ADDR    = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] CONTROL_ADDR = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] STATUS_ADDR  = 8'h0c;
    localparam logic [AXI_ADDR_W-1:0] RESULT_ADDR  = 8'h10;

    // Reset values
    localparam logic [7:0] TIMING_RESET = 8'h00;
    localparam logic [7:0] TEST_RESET   = 8'h00;

    // Timing register fields
    localparam int SAMPLE_LSB = 5;
    localparam int SAMPLE_W   = 3;
    localparam int CONVERSION_PERIOD_FIELD_LSB   = 0;
    localparam int CONVERSION_PERIOD_FIELD_W     = 5;

    // Test, control and status bits
    localparam int TEST_GROUND_BIT = 0;
    localparam int TEST_REF_BIT    = 1;
    localparam int TEST_OFFSET_LSB = 4;
    localparam int TEST_OFFSET_W   = 4;
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_TEN_BIT    = 1;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_SAMPLE_BIT = 1;
    localparam int STAT_DONE_BIT   = 2;

    // Phase arithmetic, in oscillator periods
    localparam logic [TIMER_W-1:0] SAMPLE_MULT  = 10'h008;
    localparam logic [TIMER_W-1:0] SAMPLE_EXTRA = 10'h002;
    localparam logic [TIMER_W-1:0] CONVERSION_PERIOD_FIELD_EXTRA   = 10'h003;
    localparam logic [TIMER_W-1:0] BITS_LOW     = 10'h008;
    localparam logic [TIMER_W-1:0] BITS_HIGH    = 10'h00a;
    localparam logic [TIMER_W-1:0] ONE_CYCLE    = 10'h001;
    localparam logic [TIMER_W-1:0] CONVERSION_PERIOD_FIELD_MAX     = 10'h283;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ADCT_IDLE, ADCT_SAMPLE, ADCT_CONVERT} adct_phase_type;

    function automatic logic [TIMER_W-1:0] adct_sample_cycles(input logic [SAMPLE_W-1:0] field);
        adct_sample_cycles = TIMER_W'(field) * SAMPLE_MULT + SAMPLE_EXTRA;
    endfunction

    function automatic logic [TIMER_W-1:0] adct_conversion_period_field_cycles(input logic [CONVERSION_PERIOD_FIELD_W-1:0] field, input logic ten);
        logic [TIMER_W-1:0] bits;
        bits = ten ? BITS_HIGH : BITS_LOW;
        adct_conversion_period_field_cycles = (TIMER_W'(field) + ONE_CYCLE) * (bits << 1) + CONVERSION_PERIOD_FIELD_EXTRA;
    endfunction

    // Offset is signed, in LSBs of the active resolution; result saturates at both ends
    function automatic logic [9:0] adct_apply_offset(input logic [9:0] raw, input logic [TEST_OFFSET_W-1:0] off,
                                                     input logic ten);
        logic signed [11:0] v;
        logic signed [11:0] top;
        v   = ten ? $signed({2'h0, raw}) : $signed({4'h0, raw[9:2]});
        v   = v + 12'(signed'(off));
        top = ten ? 12'sh3ff : 12'sh0ff;
        if (v < 12'sh000) begin
            adct_apply_offset = 10'h000;
        end else if (v > top) begin
            adct_apply_offset = top[9:0];
        end else begin
            adct_apply_offset = v[9:0];
        end
    endfunction

endpackage

// ==== src/adct_top.sv ====
// Converter sample and conversion phase timing with its AXI4-Lite register file
// Operation
// - One software-written timing byte sets sample and conversion length, both resolutions.
// - Sample phase lasts sample field times 8 plus 2 oscillator periods.
// - Conversion lasts (conversion field plus 1) times 2B plus 3 periods.
// - Timing works for every register value; accuracy only within rated ranges.
// - Test register selects ground or reference input and adds zero offset.
`timescale 1ns/1ps
module adct_top (
    // Clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rstn,
    // AXI4-Lite write
    input  wire logic [adct_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [adct_pkg::AXI_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    // AXI4-Lite read
    input  wire logic [adct_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [adct_pkg::AXI_DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    // Analog front end
    input  wire logic [9:0]                      raw_result,
    output logic                                 sample_enable,
    output logic                                 convert_enable,
    output logic                                 resolution_ten,
    output logic                                 select_ground,
    output logic                                 select_reference,
    output logic [adct_pkg::TEST_OFFSET_W-1:0]   zero_offset,
    output logic                                 conversion_done
);
    import adct_pkg::*;

    typedef struct packed {
        adct_phase_type        phase;
        logic [7:0]            timing;
        logic [7:0]            test;
        logic                  ctrl_ten;
        logic                  ten_latched;
        logic                  done_flag;
        logic [9:0]            result;
        logic [9:0]            raw_meta;
        logic [9:0]            raw_sync;
        logic                  aw_full;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic                  w_full;
        logic [7:0]            w_data;
        logic                  w_strb0;
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [AXI_DATA_W-1:0] rdata;
        logic [1:0]            rresp;
        logic                  sample_enable;
        logic                  convert_enable;
        logic                  select_ground;
        logic                  select_reference;
        logic                  conversion_done;
    } adct_state_type;

    adct_state_type s;
    adct_state_type next_s;
    logic [1:0]         rst_pipe;
    logic               rst_n;
    logic               timer_load;
    logic [TIMER_W-1:0] timer_value;
    logic               timer_expire;
    logic               start;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    adct_phase_timer #(
        .W (TIMER_W)
    ) u_timer (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .load       (timer_load),
        .load_value (timer_value),
        .expire     (timer_expire)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_s                 = s;
        next_s.conversion_done = 1'b0;
        timer_load             = 1'b0;
        timer_value            = '0;
        start                  = 1'b0;
        // Raw code comes from the analog side, off this clock
        next_s.raw_meta = raw_result;
        next_s.raw_sync = s.raw_meta;

        if (s_axi_awvalid && s.awready) begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_full  = 1'b1;
            next_s.w_data  = s_axi_wdata[7:0];
            next_s.w_strb0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        // All writable registers live in byte lane 0; other lanes are ignored
        if (s.aw_full && s.w_full && !s.bvalid) begin
            next_s.aw_full = 1'b0;
            next_s.w_full  = 1'b0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = RESP_OKAY;
            if (s.aw_addr == TIMING_ADDR) begin
                if (s.w_strb0) begin
                    next_s.timing = s.w_data;
                end
            end else if (s.aw_addr == TEST_ADDR) begin
                if (s.w_strb0) begin
                    next_s.test = s.w_data;
                end
            end else if (s.aw_addr == CONTROL_ADDR) begin
                if (s.w_strb0) begin
                    next_s.ctrl_ten = s.w_data[CTRL_TEN_BIT];
                    start           = s.w_data[CTRL_START_BIT];
                end
            end else if (s.aw_addr == STATUS_ADDR || s.aw_addr == RESULT_ADDR) begin
                next_s.bresp = RESP_OKAY;
            end else begin
                next_s.bresp = RESP_SLVERR;
            end
        end

        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            next_s.rdata  = '0;
            if (s_axi_araddr == TIMING_ADDR) begin
                next_s.rdata[7:0] = s.timing;
            end else if (s_axi_araddr == TEST_ADDR) begin
                next_s.rdata[7:0] = s.test;
            end else if (s_axi_araddr == CONTROL_ADDR) begin
                next_s.rdata[CTRL_TEN_BIT] = s.ctrl_ten;
            end else if (s_axi_araddr == STATUS_ADDR) begin
                next_s.rdata[STAT_BUSY_BIT]   = (s.phase != ADCT_IDLE);
                next_s.rdata[STAT_SAMPLE_BIT] = (s.phase == ADCT_SAMPLE);
                next_s.rdata[STAT_DONE_BIT]   = s.done_flag;
            end else if (s_axi_araddr == RESULT_ADDR) begin
                next_s.rdata[9:0] = s.result;
            end else begin
                next_s.rresp = RESP_SLVERR;
            end
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        // Any field value gives a finite phase; only accuracy depends on range
        case (s.phase)
            ADCT_IDLE: begin
                if (start) begin
                    next_s.phase       = ADCT_SAMPLE;
                    next_s.ten_latched = next_s.ctrl_ten;
                    next_s.done_flag   = 1'b0;
                    timer_load         = 1'b1;
                    timer_value        = adct_sample_cycles(s.timing[SAMPLE_LSB +: SAMPLE_W]) - ONE_CYCLE;
                end
            end
            ADCT_SAMPLE: begin
                if (timer_expire) begin
                    next_s.phase = ADCT_CONVERT;
                    timer_load   = 1'b1;
                    timer_value  = adct_conversion_period_field_cycles(s.timing[CONVERSION_PERIOD_FIELD_LSB +: CONVERSION_PERIOD_FIELD_W], s.ten_latched) - ONE_CYCLE;
                end
            end
            ADCT_CONVERT: begin
                if (timer_expire) begin
                    next_s.phase           = ADCT_IDLE;
                    next_s.result          = adct_apply_offset(s.raw_sync,
                                                 s.test[TEST_OFFSET_LSB +: TEST_OFFSET_W], s.ten_latched);
                    next_s.done_flag       = 1'b1;
                    next_s.conversion_done = 1'b1;
                end
            end
            default: begin
                next_s.phase = ADCT_IDLE;
            end
        endcase

        // Ready and phase outputs are registered copies of the next state
        next_s.awready          = !next_s.aw_full && !next_s.bvalid;
        next_s.wready           = !next_s.w_full && !next_s.bvalid;
        next_s.arready          = !next_s.rvalid;
        next_s.sample_enable    = (next_s.phase == ADCT_SAMPLE);
        next_s.convert_enable   = (next_s.phase == ADCT_CONVERT);
        // Ground wins when software sets both select bits
        next_s.select_ground    = next_s.test[TEST_GROUND_BIT];
        next_s.select_reference = next_s.test[TEST_REF_BIT] && !next_s.test[TEST_GROUND_BIT];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s        <= '0;
            s.phase  <= ADCT_IDLE;
            s.timing <= TIMING_RESET;
            s.test   <= TEST_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready    = s.awready;
    assign s_axi_wready     = s.wready;
    assign s_axi_bresp      = s.bresp;
    assign s_axi_bvalid     = s.bvalid;
    assign s_axi_arready    = s.arready;
    assign s_axi_rdata      = s.rdata;
    assign s_axi_rresp      = s.rresp;
    assign s_axi_rvalid     = s.rvalid;
    assign sample_enable    = s.sample_enable;
    assign convert_enable   = s.convert_enable;
    assign resolution_ten   = s.ten_latched;
    assign select_ground    = s.select_ground;
    assign select_reference = s.select_reference;
    assign zero_offset      = s.test[TEST_OFFSET_LSB +: TEST_OFFSET_W];
    assign conversion_done  = s.conversion_done;

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers: cycles spent in the current phase and its expected length
    logic [TIMER_W:0]   phase_len;
    logic [TIMER_W-1:0] exp_len;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_len <= '0;
            exp_len   <= '0;
        end else begin
            phase_len <= (next_s.phase != s.phase) ? (TIMER_W+1)'(1) : phase_len + 1'b1;
            if (timer_load) begin
                exp_len <= timer_value + ONE_CYCLE;
            end
        end
    end

    sample_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(sample_enable) |-> exp_len == TIMER_W'($past(s.timing[SAMPLE_LSB +: SAMPLE_W])) * SAMPLE_MULT + SAMPLE_EXTRA)
        else $error("sample length not field*8+2");
    sample_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(sample_enable) |-> $past(phase_len) == {1'b0, $past(exp_len)})
        else $error("sample phase length wrong");
    conversion_period_field_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(convert_enable) |-> exp_len == (TIMER_W'($past(s.timing[CONVERSION_PERIOD_FIELD_LSB +: CONVERSION_PERIOD_FIELD_W])) + ONE_CYCLE)
            * ((resolution_ten ? BITS_HIGH : BITS_LOW) << 1) + CONVERSION_PERIOD_FIELD_EXTRA)
        else $error("conversion length formula wrong");
    conversion_period_field_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(convert_enable) |-> $past(phase_len) == {1'b0, exp_len})
        else $error("conversion phase length wrong");
    phase_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(sample_enable) |-> convert_enable)
        else $error("conversion did not follow sample");
    done_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(convert_enable) |-> conversion_done ##1 !conversion_done)
        else $error("done pulse missing");
    phase_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sample_enable || convert_enable) |-> phase_len <= {1'b0, CONVERSION_PERIOD_FIELD_MAX})
        else $error("phase longer than any field allows");
    select_excl_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(select_ground && select_reference))
        else $error("ground and reference both selected");
    timing_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == TIMING_ADDR) |=> s_axi_rdata[7:0] == $past(s.timing))
        else $error("timing readback mismatch");
    bresp_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");

endmodule

// ==== verification/adct_tb.sv ====
// Self-checking bench for the converter timing block and its register file
`timescale 1ns/1ps
module tb;
    import adct_pkg::*;
    logic                  sys_clk       = 1'b0;
    logic                  rstn          = 1'b0;
    logic [AXI_ADDR_W-1:0] s_axi_awaddr  = '0;
    logic [AXI_ADDR_W-1:0] s_axi_araddr  = '0;
    logic [AXI_DATA_W-1:0] s_axi_wdata   = '0;
    logic [3:0]            s_axi_wstrb   = 4'hf;
    logic                  s_axi_awvalid = 1'b0;
    logic                  s_axi_wvalid  = 1'b0;
    logic                  s_axi_bready  = 1'b0;
    logic                  s_axi_arvalid = 1'b0;
    logic                  s_axi_rready  = 1'b0;
    logic [9:0]            raw_result    = 10'h000;
    logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]            s_axi_bresp, s_axi_rresp;
    logic [AXI_DATA_W-1:0] s_axi_rdata;
    logic                  sample_enable, convert_enable, resolution_ten, select_ground, select_reference;
    logic                  conversion_done;
    logic [TEST_OFFSET_W-1:0] zero_offset;
    logic [1:0]            bq[$];
    logic [33:0]           rq[$];
    int                    sq[$];
    int                    cq[$];
    int                    scnt          = 0;
    int                    ccnt          = 0;
    int                    fail_count    = 0;
    int                    total_checks  = 0;

    adct_top dut (
        .sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .raw_result, .sample_enable, .convert_enable, .resolution_ten, .select_ground,
        .select_reference, .zero_offset, .conversion_done
    );

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Address and data are offered together; each is released once its own ready was seen
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
        int n;
        bq.push_back(resp);
        @(posedge sys_clk);
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 200 && (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid); n++) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] addr, input logic [31:0] data, input logic [1:0] resp);
        int n;
        rq.push_back({resp, data});
        @(posedge sys_clk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 200 && (s_axi_arvalid || !s_axi_rvalid); n++) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watches the outputs and matches every result against the oldest note
    always @(posedge sys_clk) begin
        logic [33:0] e;
        if (s_axi_bvalid && s_axi_bready) begin
            compare(s_axi_bresp, bq.size() ? bq.pop_front() : 2'bxx, "write response");
        end
        if (s_axi_rvalid && s_axi_rready) begin
            e = rq.size() ? rq.pop_front() : 'x;
            compare(s_axi_rresp, e[33:32], "read response");
            if (e[33:32] == RESP_OKAY) compare(s_axi_rdata, e[31:0], "read data");
        end
        if (sample_enable) scnt++;
        else if (scnt != 0) begin
            compare(scnt, sq.size() ? sq.pop_front() : -1, "sample length");
            scnt = 0;
        end
        if (convert_enable) ccnt++;
        else if (ccnt != 0) begin
            compare(ccnt, cq.size() ? cq.pop_front() : -1, "conversion length");
            ccnt = 0;
        end
    end

    // One start with the given timing byte and mode; a second start while busy must be ignored
    task automatic convert(input logic [7:0] timing, input logic ten, input logic [9:0] raw, input logic [3:0] off);
        int n;
        int b;
        int v;
        int top;
        b = ten ? 10 : 8;
        top = ten ? 1023 : 255;
        raw_result <= raw;
        axi_write(TIMING_ADDR, {24'h0, timing}, RESP_OKAY);
        sq.push_back(int'(timing[7:5]) * 8 + 2);
        cq.push_back((int'(timing[4:0]) + 1) * 2 * b + 3);
        axi_write(CONTROL_ADDR, {30'h0, ten, 1'b1}, RESP_OKAY);
        axi_write(CONTROL_ADDR, {30'h0, ten, 1'b1}, RESP_OKAY);
        for (n = 0; n < 2000 && !conversion_done; n++) @(posedge sys_clk);
        compare(conversion_done, 1'b1, "conversion end");
        compare(resolution_ten, ten, "resolution mode");
        axi_read(CONTROL_ADDR, {30'h0, ten, 1'b0}, RESP_OKAY);
        v = (ten ? int'(raw) : int'(raw[9:2])) + int'($signed(off));
        v = v < 0 ? 0 : (v > top ? top : v);
        axi_read(RESULT_ADDR, 32'(v), RESP_OKAY);
        axi_read(STATUS_ADDR, 32'h1 << STAT_DONE_BIT, RESP_OKAY);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] timing_tab[5];
        logic [3:0] off;
        logic [9:0] raw;
        int i;
        int t;
        void'($urandom(32'h8f1a));
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        axi_read(TIMING_ADDR, {24'h0, TIMING_RESET}, RESP_OKAY);
        axi_read(TEST_ADDR, {24'h0, TEST_RESET}, RESP_OKAY);
        axi_read(8'h20, 32'h0, RESP_SLVERR);
        axi_write(8'h20, 32'hff, RESP_SLVERR);
        $display("test reset and map done");
        // Zero fields still run; in-range random fields stand for normal software
        timing_tab[0] = 8'h00;
        timing_tab[1] = 8'h22;
        timing_tab[2] = 8'hff;
        timing_tab[3] = {3'(1 + $urandom % 7), 5'(2 + $urandom % 30)};
        // Meets the rated sample and conversion windows at a 16 MHz oscillator
        timing_tab[4] = 8'h4a;
        for (i = 0; i < 5; i++) begin
            off = (i == 0) ? 4'h8 : (i == 3) ? 4'h7 : 4'($urandom);
            raw = (i == 0) ? 10'h000 : (i == 3) ? 10'h3ff : 10'($urandom);
            axi_write(TEST_ADDR, {24'h0, off, 2'h0, i[1:0]}, RESP_OKAY);
            axi_read(TEST_ADDR, {24'h0, off, 2'h0, i[1:0]}, RESP_OKAY);
            compare(select_ground, i[0], "ground select");
            compare(select_reference, i == 2, "reference select");
            compare(zero_offset, off, "zero offset");
            for (t = 0; t < 2; t++) begin
                convert(timing_tab[i], t[0], raw, off);
            end
            $display("test timing set %0d done", i);
        end
        repeat (5) @(posedge sys_clk);
        compare(bq.size() + rq.size() + sq.size() + cq.size(), 0, "unmatched notes");
        print_verdict();
    end

    // The whole test needs roughly 3000 cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
